// ---- src/fws_poller.v ----
// host side status poller and bus master for an asynchronous nor flash
// ---------------------------------------------------------------
// Summary of operation
// - start status check with two back-to-back reads, compare toggle bit.
// - toggling and timeout flag high after two reads: recheck toggle bit.
// - still toggling on recheck: operation failed, issue reset command.
// - polling suspended mid-operation restarts from the first double read.
// - after timeout failure host issues reset; device returns to read.
// - check window flag before and after extra erase; high after means rejected.
// - host presents a valid address when reading status bits.
// ---------------------------------------------------------------
`timescale 1ns/10ps
`include "fws_map.vh"
module fws_poller #(
  parameter AW = 23,
  parameter DW = 16
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [31:0]   wb_dat_i,
  input  wire [3:0]    wb_sel_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  output reg           irq,
  output reg  [AW-1:0] fl_addr,
  output reg  [DW-1:0] fl_dq_o,
  output reg           fl_dq_oe,
  input  wire [DW-1:0] fl_dq_i,
  output reg           fl_ce_n,
  output reg           fl_oe_n,
  output reg           fl_we_n,
  input  wire          ready_busy_n
);
  // ---------------------------------------------------------------
  // state codes
  // ---------------------------------------------------------------
  localparam S_IDLE  = 3'h0;
  localparam S_STRB  = 3'h1;
  localparam S_GAP   = 3'h2;
  localparam S_EVAL  = 3'h3;
  localparam S_DONE  = 3'h4;
  localparam [7:0] STROBE_C = `FWS_STROBE_CYC;
  localparam [7:0] GAP_C    = `FWS_GAP_CYC;
  // poll step codes
  localparam P_FIRST = 3'h0;
  localparam P_SECND = 3'h1;
  localparam P_RECHK = 3'h2;
  localparam P_RESET = 3'h3;
  localparam P_ARRAY = 3'h4;
  localparam P_WIN1  = 3'h5;
  localparam P_WIN2  = 3'h6;
  localparam P_WIN3  = 3'h7;
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [AW-1:0] addr_q;
  reg  [DW-1:0] wdata_q;
  reg  [DW-1:0] rdata_q;
  reg  [1:0]    op_q;
  reg  [2:0]    st_q;
  reg  [2:0]    step_q;
  reg  [7:0]    cnt_q;
  reg           prev_tgl_q;
  reg           busy_q;
  reg           done_q;
  reg           fail_q;
  reg           rej_q;
  reg  [`FWS_IRQ_W-1:0] irq_st_q;
  reg  [`FWS_IRQ_W-1:0] irq_mk_q;
  reg           rb_s1_q;
  reg           rb_s2_q;
  reg  [DW-1:0] dq_s1_q;
  reg  [DW-1:0] dq_s2_q;
  reg  [DW-1:0] cap_q;
  reg           cyc_write_q;
  reg  [`FWS_IRQ_W-1:0] ev_set;
  wire          bus_req;
  wire          wr_ctrl;
  wire          rd_irq;
  wire          cur_tgl;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire   bus_rd  = bus_req & ~wb_we_i;
  assign wr_ctrl = bus_req & wb_we_i & (wb_adr_i == `FWS_CTRL_OFS) & wb_sel_i[0]
                   & wb_dat_i[`FWS_CTRL_GO] & ~busy_q;
  assign rd_irq  = bus_rd & (wb_adr_i == `FWS_IRQ_OFS);
  assign cur_tgl = cap_q[`FWS_BIT_TOGGLE1];
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    rb_s1_q <= ready_busy_n;
    rb_s2_q <= rb_s1_q;
    dq_s1_q <= fl_dq_i;
    dq_s2_q <= dq_s1_q;
  end
  // ---------------------------------------------------------------
  // wishbone slave, answers one cycle after request
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      addr_q   <= {AW{1'b0}};
      wdata_q  <= {DW{1'b0}};
      irq_mk_q <= {`FWS_IRQ_W{1'b0}};
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req & wb_we_i & ~busy_q) begin
        case (wb_adr_i)
          `FWS_ADDR_OFS: addr_q  <= wb_dat_i[AW-1:0];
          `FWS_DATA_OFS: wdata_q <= wb_dat_i[DW-1:0];
          `FWS_MASK_OFS: irq_mk_q <= wb_dat_i[`FWS_IRQ_W-1:0];
          default: ;
        endcase
      end else if (bus_req & wb_we_i & (wb_adr_i == `FWS_MASK_OFS)) begin
        irq_mk_q <= wb_dat_i[`FWS_IRQ_W-1:0];
      end
      case (wb_adr_i)
        `FWS_CTRL_OFS:  wb_dat_o <= {29'h0, op_q, 1'b0};
        `FWS_ADDR_OFS:  wb_dat_o <= {{(32-AW){1'b0}}, addr_q};
        `FWS_DATA_OFS:  wb_dat_o <= {{(32-DW){1'b0}}, wdata_q};
        `FWS_STAT_OFS:  wb_dat_o <= {27'h0, rb_s2_q, rej_q, fail_q, done_q, busy_q};
        `FWS_IRQ_OFS:   wb_dat_o <= {29'h0, irq_st_q};
        `FWS_MASK_OFS:  wb_dat_o <= {29'h0, irq_mk_q};
        `FWS_RDATA_OFS: wb_dat_o <= {{(32-DW){1'b0}}, rdata_q};
        default:        wb_dat_o <= 32'h00000000;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // interrupt status, read clears, set wins
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      irq_st_q <= {`FWS_IRQ_W{1'b0}};
      irq      <= 1'b0;
    end else begin
      irq_st_q <= (rd_irq ? {`FWS_IRQ_W{1'b0}} : irq_st_q) | ev_set;
      irq      <= |(irq_st_q & irq_mk_q);
    end
  end
  // ---------------------------------------------------------------
  // flash bus sequencer
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      st_q        <= S_IDLE;
      step_q      <= P_FIRST;
      op_q        <= `FWS_OP_POLL;
      cnt_q       <= 8'h00;
      prev_tgl_q  <= 1'b0;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      rej_q       <= 1'b0;
      rdata_q     <= {DW{1'b0}};
      cyc_write_q <= 1'b0;
      ev_set      <= {`FWS_IRQ_W{1'b0}};
      fl_addr     <= {AW{1'b0}};
      fl_dq_o     <= {DW{1'b0}};
      fl_dq_oe    <= 1'b0;
      fl_ce_n     <= 1'b1;
      fl_oe_n     <= 1'b1;
      fl_we_n     <= 1'b1;
    end else begin
      ev_set <= {`FWS_IRQ_W{1'b0}};
      case (st_q)
        S_IDLE: begin
          if (wr_ctrl) begin
            op_q   <= wb_dat_i[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB];
            busy_q <= 1'b1;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            rej_q  <= 1'b0;
            step_q <= (wb_dat_i[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB] == `FWS_OP_ERCHK)
                      ? P_WIN1 : P_FIRST;
            cyc_write_q <= (wb_dat_i[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB] == `FWS_OP_WRITE);
            st_q   <= S_STRB;
            cnt_q  <= STROBE_C;
            fl_addr  <= addr_q;
            fl_ce_n  <= 1'b0;
            fl_oe_n  <= (wb_dat_i[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB] == `FWS_OP_WRITE);
            fl_we_n  <= (wb_dat_i[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB] != `FWS_OP_WRITE);
            fl_dq_oe <= (wb_dat_i[`FWS_CTRL_OP_MSB:`FWS_CTRL_OP_LSB] == `FWS_OP_WRITE);
            fl_dq_o  <= wdata_q;
          end
        end
        S_STRB: begin
          if (cnt_q == 8'h01) begin
            // take data while the strobe is still low
            cap_q    <= dq_s2_q;
            fl_ce_n  <= 1'b1;
            fl_oe_n  <= 1'b1;
            fl_we_n  <= 1'b1;
            st_q     <= S_GAP;
            cnt_q    <= GAP_C;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_GAP: begin
          // bus released, dq turned around
          fl_dq_oe <= 1'b0;
          if (cnt_q == 8'h01) begin
            st_q <= S_EVAL;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_EVAL: begin
          st_q  <= S_STRB;
          cnt_q <= STROBE_C;
          fl_ce_n     <= 1'b0;
          fl_oe_n     <= 1'b0;
          cyc_write_q <= 1'b0;
          prev_tgl_q  <= cur_tgl;
          if (op_q == `FWS_OP_WRITE || op_q == `FWS_OP_READ) begin
            // a write cycle leaves the read data alone
            if (!cyc_write_q) begin
              rdata_q <= cap_q;
            end
            st_q    <= S_DONE;
            fl_oe_n <= 1'b1;
            fl_ce_n <= 1'b1;
          end else begin
            case (step_q)
              P_FIRST: step_q <= P_SECND;
              P_SECND: begin
                if (cur_tgl == prev_tgl_q) begin
                  step_q <= P_ARRAY;
                end else if (cap_q[`FWS_BIT_TIMEOUT]) begin
                  step_q <= P_RECHK;
                end
              end
              P_RECHK: begin
                if (cur_tgl == prev_tgl_q) begin
                  step_q <= P_ARRAY;
                end else begin
                  fail_q   <= 1'b1;
                  step_q   <= P_RESET;
                  fl_oe_n  <= 1'b1;
                  fl_we_n  <= 1'b0;
                  fl_dq_oe <= 1'b1;
                  fl_dq_o  <= `FWS_RESET_CMD;
                end
              end
              P_RESET: begin
                ev_set[`FWS_IRQ_FAIL] <= 1'b1;
                st_q    <= S_DONE;
                fl_oe_n <= 1'b1;
                fl_ce_n <= 1'b1;
              end
              P_ARRAY: begin
                rdata_q <= cap_q;
                done_q  <= 1'b1;
                ev_set[`FWS_IRQ_DONE] <= 1'b1;
                st_q    <= S_DONE;
                fl_oe_n <= 1'b1;
                fl_ce_n <= 1'b1;
              end
              P_WIN1: begin
                if (cap_q[`FWS_BIT_WINDOW]) begin
                  rej_q   <= 1'b1;
                  ev_set[`FWS_IRQ_REJECT] <= 1'b1;
                  st_q    <= S_DONE;
                  fl_oe_n <= 1'b1;
                  fl_ce_n <= 1'b1;
                end else begin
                  step_q   <= P_WIN2;
                  fl_oe_n  <= 1'b1;
                  fl_we_n  <= 1'b0;
                  fl_dq_oe <= 1'b1;
                  fl_dq_o  <= wdata_q;
                end
              end
              P_WIN2: step_q <= P_WIN3;
              P_WIN3: begin
                if (cap_q[`FWS_BIT_WINDOW]) begin
                  rej_q <= 1'b1;
                  ev_set[`FWS_IRQ_REJECT] <= 1'b1;
                end else begin
                  done_q <= 1'b1;
                  ev_set[`FWS_IRQ_DONE] <= 1'b1;
                end
                st_q    <= S_DONE;
                fl_oe_n <= 1'b1;
                fl_ce_n <= 1'b1;
              end
              default: step_q <= P_FIRST;
            endcase
          end
        end
        S_DONE: begin
          busy_q <= 1'b0;
          if (op_q != `FWS_OP_POLL && op_q != `FWS_OP_ERCHK) begin
            done_q <= 1'b1;
            ev_set[`FWS_IRQ_DONE] <= 1'b1;
          end
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // fws_poller

// ---- src/fws_map.vh ----
// register offsets, fields and timing counts of the flash status poller
`ifndef FWS_MAP_VH
`define FWS_MAP_VH
// register byte offsets
`define FWS_CTRL_OFS      8'h00
`define FWS_ADDR_OFS      8'h04
`define FWS_DATA_OFS      8'h08
`define FWS_STAT_OFS      8'h0C
`define FWS_IRQ_OFS       8'h10
`define FWS_MASK_OFS      8'h14
`define FWS_RDATA_OFS     8'h18
// control fields
`define FWS_CTRL_GO       0
`define FWS_CTRL_OP_LSB   1
`define FWS_CTRL_OP_MSB   2
// operations
`define FWS_OP_POLL       2'h0
`define FWS_OP_WRITE      2'h1
`define FWS_OP_READ       2'h2
`define FWS_OP_ERCHK      2'h3
// status fields
`define FWS_ST_BUSY       0
`define FWS_ST_DONE       1
`define FWS_ST_FAIL       2
`define FWS_ST_REJECT     3
`define FWS_ST_RDY        4
// interrupt fields
`define FWS_IRQ_DONE      0
`define FWS_IRQ_FAIL      1
`define FWS_IRQ_REJECT    2
`define FWS_IRQ_W         3
// flash data bit positions
`define FWS_BIT_WINDOW    3
`define FWS_BIT_TIMEOUT   5
`define FWS_BIT_TOGGLE1   6
// reset command word
`define FWS_RESET_CMD     16'h00F0
// bus cycle timing in ns and derived clock counts
`define FWS_CLK_NS        5
`define FWS_STROBE_NS     70
`define FWS_STROBE_CYC    ((`FWS_STROBE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_GAP_NS        30
`define FWS_GAP_CYC       ((`FWS_GAP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`endif

// ---- tb/fws_poller_chk.sv ----
// port assertions for the flash status poller
`timescale 1ns/10ps
module fws_poller_chk #(
  parameter AW = 23,
  parameter DW = 16
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic          irq,
  input wire logic [AW-1:0] fl_addr,
  input wire logic [DW-1:0] fl_dq_o,
  input wire logic          fl_dq_oe,
  input wire logic [DW-1:0] fl_dq_i,
  input wire logic          fl_ce_n,
  input wire logic          fl_oe_n,
  input wire logic          fl_we_n,
  input wire logic          ready_busy_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  a_read_strobe: assert property ($fell(fl_oe_n) |->
    (!fl_oe_n)[*7] ##1 (!fl_oe_n)[*7] ##1 fl_oe_n) else $error("read strobe length");
  a_read_select: assert property (!fl_oe_n |-> !fl_ce_n && fl_we_n)
    else $error("read without select");
  a_read_release: assert property (!fl_oe_n |-> !fl_dq_oe) else $error("dq driven on read");
  a_write_drive: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n)
    else $error("write not driven");
  a_addr_hold: assert property (!fl_oe_n && $past(!fl_oe_n) |-> $stable(fl_addr))
    else $error("address moved");
  a_write_strobe: assert property ($fell(fl_we_n) |->
    (!fl_we_n)[*7] ##1 (!fl_we_n)[*7] ##1 fl_we_n) else $error("write strobe length");
  c_read: cover property ($fell(fl_oe_n));
  c_write: cover property ($fell(fl_we_n));
  c_irq: cover property ($rose(irq));
endmodule // fws_poller_chk
bind fws_poller fws_poller_chk #(.AW(AW), .DW(DW)) u_chk (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq(irq), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
  .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n), .ready_busy_n(ready_busy_n));

// ---- tb/fws_flash_model.sv ----
// behavioural flash device answering status reads
`timescale 1ns/10ps
module fws_flash_model (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] dq_w,
  input  wire logic [15:0] arr,
  input  wire logic        fail,
  input  wire logic        win,
  input  wire logic        arm,
  input  wire logic [7:0]  n_tog,
  input  wire logic [22:0] addr,
  input  wire logic        pgm,
  output logic [15:0]      dq_r,
  output logic             rb_n,
  output int               reads,
  output int               resets,
  output int               accepts
);
  logic        busy = 1'h0;
  logic        tog = 1'h0;
  logic [7:0]  cnt = 8'h00;
  logic [15:0] val = 16'h0000;
  initial begin
    reads = 0;
    resets = 0;
    accepts = 0;
  end
  always @(posedge arm) begin
    busy = 1'h1;
    cnt = n_tog;
  end
  always @(negedge oe_n) begin
    #1;
    if (!ce_n) begin
      reads = reads + 1;
      if (addr[22]) begin
        // upper bank is idle, answers with array data
        val = arr;
      end else if (busy && (fail || cnt != 8'h00)) begin
        cnt = cnt - 8'h01;
        tog = ~tog;
        val = pgm ? {8'h00, ~arr[7], tog, fail, 5'h00}
                  : {8'h00, 1'h0, tog, fail, 1'h0, win, tog, 2'h0};
      end else begin
        busy = 1'h0;
        val = arr;
      end
    end
  end
  always @(negedge we_n) begin
    #20;
    if (!ce_n && !we_n) begin
      if (dq_w === 16'h00F0) begin
        busy = 1'h0;
        resets = resets + 1;
      end else if (!win) begin
        accepts = accepts + 1;
      end
    end
  end
  assign dq_r = (!ce_n && !oe_n) ? val : ~val;
  assign rb_n = ~busy;
endmodule // fws_flash_model

// ---- tb/test_flash_write_status_reporting.sv ----
// self-checking bench for the flash status poller
`timescale 1ns/10ps
module test_flash_write_status_reporting;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        fail = 1'h0;
  logic        win = 1'h0;
  logic        arm = 1'h0;
  logic [7:0]  n_tog = 8'h00;
  logic        pgm = 1'h0;
  wire  [31:0] rdat;
  wire         ack;
  wire         irq;
  wire  [22:0] fl_addr;
  wire  [15:0] dq_o;
  wire  [15:0] dq_i;
  wire         dq_oe;
  wire         ce_n;
  wire         oe_n;
  wire         we_n;
  wire         rb_n;
  int          reads;
  int          resets;
  int          accepts;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  fws_poller u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq(irq), .fl_addr(fl_addr), .fl_dq_o(dq_o), .fl_dq_oe(dq_oe), .fl_dq_i(dq_i),
    .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n), .ready_busy_n(rb_n));
  fws_flash_model u_dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_w(dq_o), .arr(16'h1234),
    .fail(fail), .win(win), .arm(arm), .n_tog(n_tog), .addr(fl_addr), .pgm(pgm),
    .dq_r(dq_i), .rb_n(rb_n),
    .reads(reads), .resets(resets), .accepts(accepts));
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
  endtask
  task automatic run(input logic [1:0] op, input logic [7:0] n, output logic [31:0] s);
    n_tog <= n;
    arm <= 1'h1;
    bus(1'h1, 8'h00, {29'h0, op, 1'h1}, s);
    arm <= 1'h0;
    do bus(1'h0, 8'h0C, 32'h0, s); while (s[0] !== 1'h0);
    s = s & 32'h1F;
  endtask
  task automatic t_poll;
    logic [31:0] q;
    int r0;
    r0 = reads;
    bus(1'h1, 8'h14, 32'h7, q);
    run(2'h0, 8'h03, q);
    chk("stat", 32'h12, q);
    bus(1'h0, 8'h18, 32'h0, q);
    chk("rdata", 32'h1234, q & 32'hFFFF);
    chk("reads", 32'h1, {31'h0, reads >= r0 + 5});
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'h0, 8'h10, 32'h0, q);
    chk("irq_stat", 32'h1, q & 32'h7);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    bus(1'h0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test poll finished");
  endtask
  task automatic t_fail;
    logic [31:0] q;
    fail <= 1'h1;
    pgm <= 1'h1;
    bus(1'h1, 8'h14, 32'h1, q);
    run(2'h0, 8'h03, q);
    chk("stat", 32'h14, q);
    chk("resets", 32'h1, resets);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'h0, 8'h10, 32'h0, q);
    chk("irq_stat", 32'h2, q & 32'h7);
    fail <= 1'h0;
    pgm <= 1'h0;
    $display("test fail finished");
  endtask
  task automatic t_bank;
    logic [31:0] q;
    int r0;
    r0 = reads;
    bus(1'h1, 8'h04, 32'h400000, q);
    run(2'h0, 8'h03, q);
    chk("stat_bank", 32'h02, q);
    chk("reads_bank", 32'h3, reads - r0);
    bus(1'h0, 8'h18, 32'h0, q);
    chk("rdata_bank", 32'h1234, q & 32'hFFFF);
    $display("test bank finished");
  endtask
  task automatic t_erase;
    logic [31:0] q;
    int a0;
    a0 = accepts;
    win <= 1'h1;
    bus(1'h1, 8'h04, 32'h100, q);
    bus(1'h1, 8'h08, 32'h30, q);
    run(2'h3, 8'h02, q);
    chk("stat_rej", 32'h08, q);
    chk("acc_rej", a0, accepts);
    bus(1'h0, 8'h10, 32'h0, q);
    chk("irq_rej", 32'h4, q & 32'h7);
    win <= 1'h0;
    run(2'h3, 8'h00, q);
    chk("stat_acc", 32'h12, q);
    chk("acc", a0 + 1, accepts);
    $display("test erase finished");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_poll;
    t_fail;
    t_erase;
    t_bank;
    test_done;
  end
endmodule // test_flash_write_status_reporting
